// [logic/quad_counter_pkg.sv]
// Purpose: Shared constants and carrier types for the two-phase event counter.
// Assumes: One core clock; software access arrives as plain strobes.
// Notes: No registers sit on a public bus; control arrives on ports.
package quad_counter_pkg;
  localparam int COUNT_WIDTH = 16;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [1:0] TIMER_A2 = 2'h2;
  localparam logic [1:0] TIMER_A3 = 2'h3;
  localparam logic [1:0] TIMER_A4 = 2'h0;

  typedef enum logic [1:0] {
    proc_normal_type_val = 2'h1,
    proc_times4_type_val = 2'h2
  } proc_mode_type;

  typedef struct packed {
    logic count_start;
    logic free_run;
    logic times4;
  } control_type;

  typedef struct packed {
    logic write_strobe;
    logic [15:0] write_data;
  } sw_write_type;
endpackage : quad_counter_pkg

// [logic/two_phase_event_counter.sv]
// Purpose: 16-bit reloadable quadrature event counter for timer channels two to four.
// Assumes: Phase pins are synchronous to core_clk; edges spaced at least two cycles.
// Notes: Instantiated only for channels that support two-phase counting.
`timescale 1ns/100ps

module two_phase_event_counter #(
  parameter logic [1:0] CHANNEL = 2'h2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Two-phase pins
  input wire logic timer_phase_in_pin,
  input wire logic timer_phase_out_pin,
  // Software control
  input wire quad_counter_pkg::control_type control,
  input wire quad_counter_pkg::sw_write_type sw_write,
  // Results
  output logic [15:0] count_value,
  output logic irq_request
);
  import quad_counter_pkg::*;

  // Channels other than two, three and four keep the counter parked.
  // A4 is coded as 0 because the channel field is only two bits wide.
  localparam bit CHANNEL_OK = (CHANNEL == TIMER_A2) || (CHANNEL == TIMER_A3) ||
                              (CHANNEL == TIMER_A4);

  logic in_prev;
  logic out_prev;
  logic [15:0] counter;
  logic [15:0] reload;
  logic running;

  wire in_rise = timer_phase_in_pin & ~in_prev;
  wire in_fall = ~timer_phase_in_pin & in_prev;
  wire out_rise = timer_phase_out_pin & ~out_prev;
  wire out_fall = ~timer_phase_out_pin & out_prev;

  // Normal: only input-pin edges while the output-pin phase is high.
  wire norm_up = timer_phase_out_pin & out_prev & in_rise;
  wire norm_down = timer_phase_out_pin & out_prev & in_fall;

  // Times four: the standard quadrature decode of the previous and current pair.
  // In rising while out high is up; in falling while out high is down.
  wire x4_up = (in_rise & timer_phase_out_pin) | (in_fall & ~timer_phase_out_pin) |
               (out_rise & ~timer_phase_in_pin) | (out_fall & timer_phase_in_pin);
  wire x4_down = (in_fall & timer_phase_out_pin) | (in_rise & ~timer_phase_out_pin) |
                 (out_rise & timer_phase_in_pin) | (out_fall & ~timer_phase_in_pin);

  wire step_up = CHANNEL_OK & running & (control.times4 ? x4_up : norm_up);
  wire step_down = CHANNEL_OK & running & (control.times4 ? x4_down : norm_down);
  wire at_top = (counter == COUNT_TOP);
  wire at_bottom = (counter == COUNT_BOTTOM);
  wire wrap_up = step_up & at_top;
  wire wrap_down = step_down & at_bottom;
  wire wrap = wrap_up | wrap_down;
  wire stopped_write = sw_write.write_strobe & ~running;

  // A write that lands in the reload cycle takes effect at once, so it is not lost.
  wire [15:0] reload_source = sw_write.write_strobe ? sw_write.write_data : reload;

  logic [15:0] next_counter;
  always_comb begin
    next_counter = counter;
    if (stopped_write) begin
      next_counter = sw_write.write_data;
    end else if (wrap && !control.free_run) begin
      next_counter = reload_source;
    end else if (step_up) begin
      next_counter = counter + 16'h0001;
    end else if (step_down) begin
      next_counter = counter - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_prev <= 1'b0;
      out_prev <= 1'b0;
    end else begin
      in_prev <= timer_phase_in_pin;
      out_prev <= timer_phase_out_pin;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
    end else begin
      running <= control.count_start;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reload <= RELOAD_RESET;
    end else if (sw_write.write_strobe) begin
      reload <= sw_write.write_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter <= COUNTER_RESET;
    end else begin
      counter <= next_counter;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_value <= COUNTER_RESET;
      irq_request <= 1'b0;
    end else begin
      count_value <= next_counter;
      irq_request <= wrap;
    end
  end

  // Assertions.
  reload_on_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrap && !control.free_run && !sw_write.write_strobe && running) |=> (counter == $past(reload)))
    else $error("counter did not reload on wrap");
  free_run_up_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrap_up && control.free_run && !sw_write.write_strobe) |=> (counter == 16'h0000))
    else $error("free-run up wrap did not reach zero");
  free_run_dn_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrap_down && control.free_run && !sw_write.write_strobe) |=> (counter == 16'hFFFF))
    else $error("free-run down wrap did not reach top");
  irq_on_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wrap |=> irq_request)
    else $error("interrupt request missing after wrap");
  irq_only_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    irq_request |-> $past(wrap))
    else $error("interrupt request without wrap");
  stopped_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!running && !sw_write.write_strobe) |=> (counter == $past(counter)))
    else $error("counter moved while stopped");
  stopped_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    stopped_write |=> (counter == $past(sw_write.write_data) && reload == counter))
    else $error("stopped write did not load both");
  running_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (sw_write.write_strobe && running && !step_up && !step_down) |=> (counter == $past(counter)))
    else $error("running write disturbed counter");
  norm_up_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (running && !control.times4 && norm_up && !at_top && !sw_write.write_strobe)
      |=> (counter == $past(counter) + 16'h0001))
    else $error("normal mode did not count up");
  x4_down_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (running && control.times4 && x4_down && !at_bottom && !sw_write.write_strobe)
      |=> (counter == $past(counter) - 16'h0001))
    else $error("times four did not count down");
  read_value_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 (count_value == counter))
    else $error("read value differs from counter");
  x4_up_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (running && control.times4 && x4_up && !at_top && !sw_write.write_strobe)
      |=> (counter == $past(counter) + 16'h0001))
    else $error("times four did not count up");
  norm_down_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (running && !control.times4 && norm_down && !at_bottom && !sw_write.write_strobe)
      |=> (counter == $past(counter) - 16'h0001))
    else $error("normal mode did not count down");
  no_event_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!step_up && !step_down && !stopped_write) |=> (counter == $past(counter)))
    else $error("counter moved without an event");
  norm_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!control.times4 && !timer_phase_out_pin) |-> (!step_up && !step_down))
    else $error("normal mode counted with output phase low");
  start_run_a: assert property (@(posedge core_clk) disable iff (!resetn)
    control.count_start |=> running)
    else $error("start flag did not start counting");
  stop_halt_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !control.count_start |=> !running)
    else $error("clear start flag did not halt counting");
  channel_park_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !CHANNEL_OK |-> (!step_up && !step_down))
    else $error("unsupported channel counted");

  // Covers show the main paths were exercised; they do not check anything.
  stop_write_c: cover property (@(posedge core_clk) disable iff (!resetn) stopped_write);

  up_wrap_c: cover property (@(posedge core_clk) disable iff (!resetn) wrap_up);
  down_wrap_c: cover property (@(posedge core_clk) disable iff (!resetn) wrap_down);
  x4_up_c: cover property (@(posedge core_clk) disable iff (!resetn)
    (running && control.times4 && x4_up));
  run_write_c: cover property (@(posedge core_clk) disable iff (!resetn)
    (running && sw_write.write_strobe));
endmodule : two_phase_event_counter

// [verif/quad_source.sv]
// Purpose: Two-phase pulse source standing in for an encoder on the phase pins.
// Assumes: The bench asks for one quarter step at a time, spaced by two cycles or more.
// Notes: The Gray order below is the only legal path, so both pins never move together.
`timescale 1ns/100ps
module quad_source (
  // Clock
  input wire logic core_clk,
  // Step request
  input wire logic step,
  input wire logic dir,
  // Phase pins
  output logic phase_in,
  output logic phase_out
);
  logic [1:0] idx = 2'h0;
  always_ff @(posedge core_clk) begin
    if (step) begin
      idx <= dir ? idx + 2'h1 : idx - 2'h1;
    end
  end
  assign phase_in = idx[1];
  assign phase_out = idx[1] ^ idx[0];
endmodule : quad_source

// [verif/tb.sv]
// Purpose: Self-checking bench for the two-phase event counter.
// Assumes: Inputs move 1 ns after the rising edge; outputs are read 5 ns after it.
// Notes: Every expected change of count or request is queued before it is due.
`timescale 1ns/100ps
module tb;
  import quad_counter_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, step = 1'b0, dir = 1'b0;
  logic pin_in, pin_out, irq_request;
  control_type control = '0;
  sw_write_type sw_write = '0;
  logic [15:0] count_value, last_val = 16'h0000, exp_cnt = 16'h0000, exp_rel = 16'h0000;
  logic [16:0] notes[$];
  logic [1:0] idx = 2'h0;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  quad_source src_u (.core_clk(core_clk), .step(step), .dir(dir), .phase_in(pin_in),
    .phase_out(pin_out));
  two_phase_event_counter #(.CHANNEL(TIMER_A3)) dut_u (.core_clk(core_clk), .resetn(resetn),
    .timer_phase_in_pin(pin_in), .timer_phase_out_pin(pin_out), .control(control),
    .sw_write(sw_write), .count_value(count_value), .irq_request(irq_request));
  task check(input logic [16:0] seen, input logic [16:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task test_done;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // A write while running only moves the reload value, so no change is queued.
  task wr(input logic [15:0] d);
    exp_rel = d;
    if (!control.count_start && d !== exp_cnt) notes.push_back({1'b0, d});
    if (!control.count_start) exp_cnt = d;
    sw_write = '{1'b1, d};
    tick(1);
    sw_write.write_strobe = 1'b0;
  endtask : wr
  task mv(input logic up);
    logic w;
    if (control.count_start && (control.times4 || idx == (up ? 2'h1 : 2'h2))) begin
      w = up ? exp_cnt == 16'hFFFF : exp_cnt == 16'h0000;
      exp_cnt = (w && !control.free_run) ? exp_rel : (up ? exp_cnt + 16'h1 : exp_cnt - 16'h1);
      notes.push_back({w, exp_cnt});
    end
    idx = up ? idx + 2'h1 : idx - 2'h1;
    dir = up;
    step = 1'b1;
    tick(1);
    step = 1'b0;
    tick(1);
  endtask : mv
  always @(posedge core_clk) begin
    #5;
    cycles++;
    if (count_value !== last_val || irq_request !== 1'b0) begin
      if (notes.size() > 0) check({irq_request, count_value}, notes.pop_front());
      else check({irq_request, count_value}, {1'b0, last_val});
    end
    last_val = count_value;
    if (cycles > 3000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h99C783E3));
    tick(6);
    resetn = 1'b1;
    tick(1);
    wr(16'hFFFE);
    control = '{1'b1, 1'b0, 1'b1};
    tick(1);
    repeat (4) mv(1'b1);
    wr(16'($urandom));
    repeat (3) mv(1'b1);
    control.count_start = 1'b0;
    tick(1);
    repeat (4) mv(1'b1);
    wr(16'h0002);
    control.count_start = 1'b1;
    tick(1);
    repeat (7) mv(1'b0);
    control.free_run = 1'b1;
    repeat (6) mv(1'b1);
    repeat (9) mv(1'b0);
    control = '{1'b1, 1'b0, 1'b0};
    repeat (9) mv(1'b1);
    repeat (9) mv(1'b0);
    for (int i = 0; i < 300; i++) begin
      control.times4 = 1'($urandom);
      control.free_run = 1'($urandom);
      if ($urandom % 8 == 0) wr(16'($urandom % 4) - 16'h2);
      mv(1'($urandom));
    end
    tick(4);
    check({16'h0, notes.size() == 0}, 17'h1);
    test_done();
  end
endmodule : tb
